// File: rtl/adc_parallel_host_port.sv
/*
 Parallel host port of a four-input sampling converter: selects, strobes,
 12-bit data bus split into in/out/enable, control registers, sync marker,
 pacing-clock driven result pipeline and output FIFO.
 Assumes host pins and the pacing clock are asynchronous to clk and that
 clk is several times faster than the pacing clock.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_parallel_host_port
   import adc_port_pkg::*;
#(
   parameter int LATENCY = adc_port_pkg::PIPE_LAT
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host selects and strobes
   input wire logic select_low_n,
   input wire logic select_high,
   input wire logic readStrobe_n,
   input wire logic writeStrobe,
   // data bus, enable low while driving
   input wire logic [adc_port_pkg::DATA_W-1:0] dataIn,
   output logic [adc_port_pkg::DATA_W-1:0] dataOut,
   output logic dataOe_n,
   // conversion side
   input wire logic sample_pacing_clock,
   input wire logic [adc_port_pkg::DATA_W-1:0] sampleCode,
   // status and configuration out
   output logic sync_n,
   output logic useExtRef,
   output logic [1:0] chanCount,
   output logic initDone,
   output logic fifoOverflow
);
   import adc_port_pkg::*;

   // two-flop synchronisers for pins
   logic [4:0] pinMeta;
   logic [4:0] pinSync;
   logic [DATA_W-1:0] dataMeta;
   logic [DATA_W-1:0] dataSync;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pinMeta <= 5'h03;
         pinSync <= 5'h03;
         dataMeta <= '0;
         dataSync <= '0;
      end else begin
         pinMeta <= {sample_pacing_clock, select_high, select_low_n, readStrobe_n, writeStrobe};
         pinSync <= pinMeta;
         dataMeta <= dataIn;
         dataSync <= dataMeta;
      end
   end
   wire wrS = pinSync[0];
   wire rdS_n = pinSync[1];
   wire csLoS_n = pinSync[2];
   wire csHiS = pinSync[3];
   wire pacingS = pinSync[4];

   logic [9:0] ctrl0;
   logic [9:0] ctrl1;
   logic wrPrev;
   logic readPrev;
   logic pacingPrev;

   wire selected = !csLoS_n && csHiS;
   wire writeOnly = ctrl1[CR1_WRONLY_BIT];
   // combined mode: writeStrobe high = read, low = write
   wire readActive = writeOnly ? !rdS_n : wrS;
   wire writeLevel = writeOnly ? !wrS : !wrS;
   // until the first write the strobe mode is unknown, so reads wait for init
   wire readQual = selected && readActive && initDone;
   wire writeQual = selected && writeLevel && !(initDone && readActive);
   wire writeStart = writeQual && !wrPrev;
   wire readEnd = readPrev && !readQual;
   wire [1:0] regAddr = dataSync[ADDR_HI:ADDR_LO];
   wire pacingFall = pacingPrev && !pacingS;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctrl0 <= CR0_RESET;
         ctrl1 <= CR1_RESET;
         initDone <= 1'b0;
         wrPrev <= 1'b0;
         readPrev <= 1'b0;
         pacingPrev <= 1'b0;
      end else begin
         wrPrev <= writeQual;
         readPrev <= readQual;
         pacingPrev <= pacingS;
         if (writeStart) begin
            initDone <= 1'b1;
            if (regAddr == ADDR_CR0) ctrl0 <= dataSync[9:0];
            if (regAddr == ADDR_CR1) ctrl1 <= dataSync[9:0];
         end
      end
   end

   // pipeline of LATENCY stages on pacing edges, tagged with channel index
   logic [DATA_W-1:0] pipeData [LATENCY];
   logic [1:0] pipeChan [LATENCY];
   logic [LATENCY-1:0] pipeValid;
   logic [1:0] chanIdx;
   wire [1:0] chanMax = ctrl0[CR0_CHAN_HI:CR0_CHAN_LO];
   wire syncReset = writeStart && regAddr == ADDR_CR1 && dataSync[CR1_SYNCRST_BIT];
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         chanIdx <= '0;
         pipeValid <= '0;
      end else if (syncReset) begin
         chanIdx <= '0;
         pipeValid <= '0;
      end else if (pacingFall) begin
         chanIdx <= (chanIdx == chanMax) ? 2'h0 : chanIdx + 2'h1;
         pipeValid <= {pipeValid[LATENCY-2:0], 1'b1};
      end
   end
   genvar g;
   generate
      for (g = 0; g < LATENCY; g++) begin : gStage
         always_ff @(posedge clk) begin
            if (pacingFall) begin
               pipeData[g] <= (g == 0) ? sampleCode : pipeData[(g == 0) ? 0 : g-1];
               pipeChan[g] <= (g == 0) ? chanIdx : pipeChan[(g == 0) ? 0 : g-1];
            end
         end
      end
   endgenerate
   wire resultValid = pacingFall && pipeValid[LATENCY-1];

   // FIFO: word = {channel, code}
   logic fifoInReady;
   logic fifoOutValid;
   logic [DATA_W+1:0] fifoOutData;
   sample_fifo #(.WIDTH(DATA_W+2), .DEPTH(FIFO_DEPTH)) uFifo (
      .clk(clk),
      .sys_rst(sys_rst),
      .inValid(resultValid),
      .inReady(fifoInReady),
      .inData({pipeChan[LATENCY-1], pipeData[LATENCY-1]}),
      .outValid(fifoOutValid),
      .outReady(readEnd),
      .outData(fifoOutData)
   );

   wire multiChan = (chanMax != 2'h0);
   wire firstChan = fifoOutData[DATA_W+1:DATA_W] == 2'h0;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         dataOut <= '0;
         dataOe_n <= 1'b1;
         sync_n <= 1'b1;
         useExtRef <= 1'b0;
         chanCount <= 2'h0;
         fifoOverflow <= 1'b0;
      end else begin
         dataOut <= fifoOutData[DATA_W-1:0];
         dataOe_n <= !readQual;
         sync_n <= !(multiChan && fifoOutValid && firstChan);
         useExtRef <= ctrl0[CR0_EXTREF_BIT];
         chanCount <= chanMax;
         fifoOverflow <= fifoOverflow || (resultValid && !fifoInReady);
      end
   end
endmodule : adc_parallel_host_port
`default_nettype wire

// File: rtl/adc_port_pkg.sv
/*
 Package of constants for the converter's parallel host port.
 Assumes one system clock; host pins and the pacing clock arrive asynchronously.
*/
// Function
// - the port is selected only while select_low_n is low and select_high is high.
// - the data bus is 12 bits, bidirectional, released when idle, bit 0 least significant.
// - during a register write the top two data lines carry the register address.
// - the write strobe is configurable as a combined read/write line or a write-only strobe.
// - in write-only mode a low write strobe marks a write and the read strobe marks reads.
// - the read strobe is honoured only in write-only mode and ignored otherwise.
// - in multichannel operation the sync output marks the read of the first channel's result.
// - conversions are paced by the external pacing clock.
// - a bit of control register 0 selects the internal or external reference.
// - each falling pacing edge starts a conversion and its result appears five edges later.
// - sync is active low for the first channel and stays high in single-channel mode.
// - a read is qualified only after the first write, with both selects and the read strobe (write-only mode) or a high write strobe active.
package adc_port_pkg;
   localparam int DATA_W = 12;
   localparam int PIPE_LAT = 5;
   localparam int FIFO_DEPTH = 16;
   localparam logic [1:0] ADDR_CR0 = 2'h0;
   localparam logic [1:0] ADDR_CR1 = 2'h1;
   localparam int ADDR_HI = 11;
   localparam int ADDR_LO = 10;
   // control register 0 fields
   localparam int CR0_EXTREF_BIT = 0;
   localparam int CR0_CHAN_LO = 1;
   localparam int CR0_CHAN_HI = 2;
   // control register 1 fields
   localparam int CR1_WRONLY_BIT = 0;
   localparam int CR1_SYNCRST_BIT = 1;
   localparam logic [9:0] CR0_RESET = 10'h000;
   localparam logic [9:0] CR1_RESET = 10'h000;
endpackage : adc_port_pkg

// File: rtl/sample_fifo.sv
/*
 Sample FIFO in flip-flops with valid/ready on both sides.
 Assumes a single clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // write side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // read side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;
   assign inReady = (count != (AW+1)'(DEPTH));
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (push) wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
         if (pop) rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge clk) begin
      if (push) mem[wrPtr] <= inData;
   end
endmodule : sample_fifo
`default_nettype wire

// File: sim/port_monitor.sv
/* assertion checker for the host port
   bound to the port's top module, sees its ports only */
`timescale 1ns/1ps
`default_nettype none
module port_checker
   import adc_port_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // host side
   input wire logic select_low_n,
   input wire logic select_high,
   input wire logic writeStrobe,
   input wire logic [adc_port_pkg::DATA_W-1:0] dataIn,
   input wire logic dataOe_n,
   // status
   input wire logic sync_n,
   input wire logic useExtRef,
   input wire logic [1:0] chanCount,
   input wire logic initDone
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   wire logic sel = !select_low_n && select_high;
   wire logic wr = sel && !writeStrobe;
   bus_idle_a: assert property (!sel [*5] |-> dataOe_n) else $error("bus driven unselected");
   read_qual_a: assert property ($fell(dataOe_n) |-> $past(sel, 2) && $past(sel, 3)) else $error("bad read");
   early_read_a: assert property (!initDone |-> dataOe_n) else $error("read before init");
   init_keep_a: assert property (initDone |=> initDone) else $error("init lost");
   write_take_a: assert property (wr [*3] |-> ##[0:1] initDone) else $error("write missed");
   cfg_load_a: assert property ((wr && dataIn[11:10] == ADDR_CR0) [*4] |-> ##[0:1]
      useExtRef == dataIn[0] && chanCount == dataIn[2:1]) else $error("config not loaded");
   cfg_keep_a: assert property (!wr [*4] |=> $stable(useExtRef) && $stable(chanCount)) else $error("cfg moved");
   sync_one_a: assert property (chanCount == 2'h0 && $past(chanCount) == 2'h0 |-> sync_n) else $error("sync");
   reset_out_a: assert property ($fell(sys_rst) |-> dataOe_n && sync_n && !initDone) else $error("reset");
endmodule : port_checker
bind adc_parallel_host_port port_checker i_chk (.clk, .sys_rst, .select_low_n, .select_high, .writeStrobe,
   .dataIn, .dataOe_n, .sync_n, .useExtRef, .chanCount, .initDone);
`default_nettype wire

// File: sim/host_model.sv
/* host bus model: selects, strobes and write data
   assumes the bench calls wr and rd one at a time */
`timescale 1ns/1ps
`default_nettype none
module host_model
   import adc_port_pkg::*;
(
   // clock
   input wire logic clk,
   // device answer
   input wire logic dataOe_n,
   input wire logic [adc_port_pkg::DATA_W-1:0] dataOut,
   // host pins
   output logic select_low_n,
   output logic select_high,
   output logic readStrobe_n,
   output logic writeStrobe,
   output logic [adc_port_pkg::DATA_W-1:0] dataIn
);
   logic wrOnly = '0;
   initial begin
      {select_low_n, select_high, readStrobe_n, writeStrobe} = 4'hb;
      dataIn = '0;
   end
   // strobe low before select, so no false read
   task automatic wr(input logic [1:0] a, input logic [9:0] v);
      @(posedge clk);
      writeStrobe <= '0;
      dataIn <= {a, v};
      @(posedge clk);
      {select_low_n, select_high} <= 2'h1;
      repeat (5) @(posedge clk);
      {select_low_n, select_high} <= 2'h2;
      @(posedge clk);
      writeStrobe <= '1;
      dataIn <= ~{a, v};
      repeat (4) @(posedge clk);
   endtask : wr
   task automatic rd(output logic [DATA_W-1:0] d, output logic ok);
      @(posedge clk);
      {select_low_n, select_high} <= 2'h1;
      readStrobe_n <= !wrOnly;
      ok = '0;
      for (int n = 0; n < 8 && !ok; n++) begin
         @(posedge clk);
         ok = dataOe_n === 1'h0;
         d = dataOut;
      end
      repeat (3) @(posedge clk);
      {select_low_n, select_high, readStrobe_n} <= 3'h5;
      repeat (5) @(posedge clk);
   endtask : rd
endmodule : host_model
`default_nettype wire

// File: sim/testbench.sv
/* self-checking bench for the host port
   host model drives the pins, bench paces conversions */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import adc_port_pkg::*;
   logic clk = '0;
   logic sys_rst = '1;
   logic pace = '1;
   logic pacOn = '0;
   logic [3:0] pCnt = '0;
   logic [15:0] rnd = 16'he8d2;
   logic [DATA_W-1:0] sampleCode = '0;
   logic [DATA_W-1:0] q[$];
   int falls = 0;
   int num_errors = 0;
   int cmp_count = 0;
   wire logic select_low_n, select_high, readStrobe_n, writeStrobe, dataOe_n;
   wire logic sync_n, useExtRef, initDone, fifoOverflow;
   wire logic [DATA_W-1:0] dataIn, dataOut;
   wire logic [1:0] chanCount;
   always #12.5 clk = ~clk;
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // pacing clock of 32 cycles, rests high when off
   always @(posedge clk) begin
      pCnt <= pCnt + 4'h1;
      rnd <= lfsr(rnd);
      if (pace && pCnt == 4'h8) sampleCode <= rnd[11:0];
      if (&pCnt) pace <= !pace || !pacOn;
      if (&pCnt && pace && pacOn) begin
         q.push_back(sampleCode);
         falls <= falls + 1;
      end
   end
   host_model i_host (.clk, .dataOe_n, .dataOut, .select_low_n, .select_high, .readStrobe_n, .writeStrobe,
      .dataIn);
   adc_parallel_host_port i_dut (.clk, .sys_rst, .select_low_n, .select_high, .readStrobe_n, .writeStrobe,
      .dataIn, .dataOut, .dataOe_n, .sample_pacing_clock(pace), .sampleCode, .sync_n, .useExtRef, .chanCount,
      .initDone, .fifoOverflow);
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : report_and_stop
   // tests need about 40 us
   initial begin
      #200us;
      num_errors++;
      report_and_stop();
   end
   initial begin
      logic [DATA_W-1:0] d;
      logic ok;
      int tgt;
      repeat (3) @(posedge clk);
      sys_rst <= '0;
      repeat (2) @(posedge clk);
      i_host.rd(d, ok);
      chk("early read", ok, 1'h0);
      $display("test 1 done");
      i_host.wr(ADDR_CR0, 10'h001);
      chk("ext ref", useExtRef, 1'h1);
      chk("init", initDone, 1'h1);
      i_host.wr(2'h2, rnd[9:0]);
      chk("chans", chanCount, 2'h0);
      $display("test 2 done");
      pacOn <= '1;
      for (int n = 0; n < 2000 && falls < 22; n++) @(posedge clk);
      pacOn <= '0;
      repeat (40) @(posedge clk);
      chk("falls", 16'(falls), 16'd22);
      chk("overflow", fifoOverflow, 1'h1);
      $display("test 3 done");
      for (int i = 0; i < 16; i++) begin
         if (i == 8) begin
            i_host.wr(ADDR_CR1, 10'h001);
            i_host.wrOnly = '1;
         end
         i_host.rd(d, ok);
         chk("read ok", ok, 1'h1);
         chk("data", d, q[i]);
         chk("sync", sync_n, 1'h1);
      end
      $display("test 4 done");
      // two channels, pipeline restarted by the sync reset bit
      i_host.wr(ADDR_CR0, 10'h002);
      i_host.wr(ADDR_CR1, 10'h003);
      chk("chans two", chanCount, 2'h1);
      tgt = falls + 9;
      pacOn <= '1;
      for (int n = 0; n < 1000 && falls < tgt; n++) @(posedge clk);
      pacOn <= '0;
      repeat (40) @(posedge clk);
      chk("falls two", 16'(falls), 16'(tgt));
      for (int i = 0; i < 4; i++) begin
         chk("sync head", sync_n, (i % 2 == 0) ? 1'h0 : 1'h1);
         i_host.rd(d, ok);
         chk("read ok two", ok, 1'h1);
         chk("data two", d, q[tgt-9+i]);
      end
      chk("sync empty", sync_n, 1'h1);
      $display("test 5 done");
      report_and_stop();
   end
endmodule : testbench
`default_nettype wire
